// ===== hdl/pbpc_pkg.sv
// Purpose: Shared constants and carrier types for the eight-bit port B pin control block.
// Assumes: One 200 MHz clock; registers sit on a plain 20-bit address port.
// Notes: Offsets are the lower 20 bits of the CPU address.
package pbpc_pkg;

  // ==========================================================================
  // Register map and widths
  // ==========================================================================
  localparam int PBPC_ADDR_W = 20;
  localparam int PBPC_DATA_W = 8;
  localparam logic [19:0] PBPC_DIR_OFFSET = 20'hE_E00A;
  localparam logic [19:0] PBPC_LATCH_OFFSET = 20'hF_FFDA;

  // ==========================================================================
  // Reset values and read answers
  // ==========================================================================
  localparam logic [7:0] PBPC_DIR_RESET = 8'h00;
  localparam logic [7:0] PBPC_LATCH_RESET = 8'h00;
  localparam logic [7:0] PBPC_DIR_READ = 8'hFF;
  localparam logic [7:0] PBPC_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] PBPC_OE_N_IDLE = 8'hFF;

  // ==========================================================================
  // Pin positions of the shared upper pins
  // ==========================================================================
  localparam int PBPC_PIN_RX = 7;
  localparam int PBPC_PIN_TX = 6;
  localparam int PBPC_PIN_CLK = 5;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  // Settings coming from the serial, pattern and DRAM units.
  typedef struct packed {
    logic [2:0] patternEnable;
    logic [2:0] patternOut;
    logic smartCardSelect;
    logic receiverEnable;
    logic transmitterEnable;
    logic clockEnableLo;
    logic clockEnableHi;
    logic syncSelect;
    logic serialTxData;
    logic serialTxDrive;
    logic serialClkData;
    logic lowerColumnStrobeSel;
    logic lowerColumnStrobe;
  } pbpc_periph_t;

  // Values handed back to the serial unit.
  typedef struct packed {
    logic serialRxIn;
    logic serialClkIn;
  } pbpc_to_periph_t;

  // Register port request.
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pbpc_bus_req_t;

endpackage : pbpc_pkg

// ===== hdl/pbpc_sync.sv
// Purpose: Three-stage pin synchroniser; the output moves once stages two and three agree.
// Assumes: Inputs are asynchronous to clk.
// Notes: Stage one feeds stage two only.
`timescale 1ns/1ps
module pbpc_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level in, filtered level out.
  input wire logic [W-1:0] async,
  output logic [W-1:0] level
);
  import pbpc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } pbpc_sync_state_t;

  pbpc_sync_state_t state_q;
  pbpc_sync_state_t state_d;

  // A bit takes the new level only when the two later stages agree.
  always_comb
  begin
    state_d = state_q;
    state_d.s1 = async;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (state_q.s2[i] == state_q.s3[i])
      begin
        state_d.stable[i] = state_q.s3[i];
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign level = state_q.stable;

endmodule : pbpc_sync

// ===== hdl/pbpc_port.sv
// Purpose: Eight-bit port B with direction and output registers and upper pin muxing.
// Assumes: Peripheral settings arrive on clk; pins are asynchronous and pass a synchroniser.
// Notes: Pin drive and enable are registered, so a change reaches the pins one cycle later.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module pbpc_port #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Standby controls.
  input wire logic hwStandby,
  input wire logic swStandby,
  // Register port.
  input wire logic [pbpc_pkg::PBPC_ADDR_W-1:0] busAddr,
  input wire logic [pbpc_pkg::PBPC_DATA_W-1:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [pbpc_pkg::PBPC_DATA_W-1:0] busRdata,
  // Peripheral side.
  input wire pbpc_pkg::pbpc_periph_t periph,
  output pbpc_pkg::pbpc_to_periph_t toPeriph,
  // Pins.
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut,
  output logic [W-1:0] pinOe_n
);
  import pbpc_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [W-1:0] dir;
    logic [W-1:0] latch;
    logic [W-1:0] drive;
    logic [W-1:0] oeN;
    logic [7:0] rdata;
    logic rxIn;
    logic clkIn;
  } pbpc_state_t;

  pbpc_state_t state_q;
  pbpc_state_t state_d;
  logic [W-1:0] pinLevel;
  logic [W-1:0] muxDrive;
  logic [W-1:0] muxOeN;
  logic [W-1:0] portRead;
  logic [W-1:0] pinTaken;
  logic hitDir;
  logic hitLatch;
  logic rxOwned;
  logic txOwned;
  logic clkOut;
  logic clkInSel;

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  pbpc_sync #(
    .W(W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async(pinIn),
    .level(pinLevel)
  );

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Only the lower 20 address bits take part in the match.
  assign hitDir = (busAddr == PBPC_DIR_OFFSET);
  assign hitLatch = (busAddr == PBPC_LATCH_OFFSET);

  // Port read mixes latch and pin level bit by bit.
  assign portRead = (state_q.dir & state_q.latch) | (~state_q.dir & pinLevel);

  // ==========================================================================
  // Upper pin function selection
  // ==========================================================================
  // Peripheral ownership of the three shared pins.
  always_comb
  begin
    rxOwned = periph.receiverEnable | periph.smartCardSelect;
    txOwned = periph.transmitterEnable | periph.smartCardSelect;
    clkOut = ~periph.clockEnableHi & (periph.clockEnableLo | periph.syncSelect);
    clkInSel = periph.clockEnableHi;
  end

  // Pin drive and enable before the standby freeze.
  always_comb
  begin
    muxDrive = state_q.latch;
    muxOeN = ~state_q.dir;
    pinTaken = '0;
    // Pattern output replaces the latch only on pins set as outputs.
    for (int i = 0; i < 3; i++)
    begin
      if (state_q.dir[PBPC_PIN_CLK + i] && periph.patternEnable[i])
      begin
        muxDrive[PBPC_PIN_CLK + i] = periph.patternOut[i];
      end
    end
    // Pin 7 becomes the serial receive input.
    if (rxOwned)
    begin
      pinTaken[PBPC_PIN_RX] = 1'b1;
      muxDrive[PBPC_PIN_RX] = 1'b0;
      muxOeN[PBPC_PIN_RX] = 1'b1;
    end
    // Pin 6 becomes the serial transmit output; smart card mode may float it.
    if (txOwned)
    begin
      pinTaken[PBPC_PIN_TX] = 1'b1;
      muxDrive[PBPC_PIN_TX] = periph.serialTxData;
      if (periph.smartCardSelect)
      begin
        muxOeN[PBPC_PIN_TX] = ~periph.serialTxDrive;
      end
      else
      begin
        muxOeN[PBPC_PIN_TX] = 1'b0;
      end
    end
    // Pin 5: column strobe first, then serial clock, then general use.
    if (periph.lowerColumnStrobeSel)
    begin
      pinTaken[PBPC_PIN_CLK] = 1'b1;
      muxDrive[PBPC_PIN_CLK] = periph.lowerColumnStrobe;
      muxOeN[PBPC_PIN_CLK] = 1'b0;
    end
    else if (clkInSel)
    begin
      pinTaken[PBPC_PIN_CLK] = 1'b1;
      muxDrive[PBPC_PIN_CLK] = 1'b0;
      muxOeN[PBPC_PIN_CLK] = 1'b1;
    end
    else if (clkOut)
    begin
      pinTaken[PBPC_PIN_CLK] = 1'b1;
      muxDrive[PBPC_PIN_CLK] = periph.serialClkData;
      muxOeN[PBPC_PIN_CLK] = 1'b0;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Register writes, read answer, pin freeze in software standby.
  always_comb
  begin
    state_d = state_q;
    // Register writes keep working in software standby; only pins freeze.
    if (busWr && hitDir)
    begin
      state_d.dir = busWdata[W-1:0];
    end
    if (busWr && hitLatch)
    begin
      state_d.latch = busWdata[W-1:0];
    end
    // The read answer stands only in the cycle after the strobe.
    state_d.rdata = PBPC_UNMAPPED_READ;
    if (busRd && hitDir)
    begin
      state_d.rdata = PBPC_DIR_READ;
    end
    else if (busRd && hitLatch)
    begin
      state_d.rdata = portRead;
    end
    // Pins hold their last drive for the whole software standby period.
    if (!swStandby)
    begin
      state_d.drive = muxDrive;
      state_d.oeN = muxOeN;
    end
    else
    begin
      state_d.drive = state_q.drive;
      state_d.oeN = state_q.oeN;
    end
    // Serial receive follows synchronised pin 7 when the receiver owns it; serial clock in follows pin 5 whenever clockEnableHi is set.
    state_d.rxIn = rxOwned ? pinLevel[PBPC_PIN_RX] : 1'b1;
    state_d.clkIn = clkInSel ? pinLevel[PBPC_PIN_CLK] : 1'b0;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset and hardware standby load the reset values here and float all pins; the synchroniser clears on reset only.
  always_ff @(posedge clk)
  begin
    if (!rst_n || hwStandby)
    begin
      state_q.dir <= PBPC_DIR_RESET;
      state_q.latch <= PBPC_LATCH_RESET;
      state_q.drive <= '0;
      state_q.oeN <= PBPC_OE_N_IDLE;
      state_q.rdata <= PBPC_UNMAPPED_READ;
      state_q.rxIn <= 1'b1;
      state_q.clkIn <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign busRdata = state_q.rdata;
  assign pinOut = state_q.drive;
  assign pinOe_n = state_q.oeN;
  assign toPeriph.serialRxIn = state_q.rxIn;
  assign toPeriph.serialClkIn = state_q.clkIn;

endmodule : pbpc_port

// ===== sim/pbpc_monitor.sv
// Purpose: Port-level assertions for the port B pin control block.
// Assumes: One clock; rst_n synchronous, active low.
// Notes: Attached to pbpc_port by the bind at the foot.
`timescale 1ns/1ps
module pbpc_monitor #(
  parameter int W = 8
) (
  // Clock, reset and standby.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hwStandby,
  input wire logic swStandby,
  // Register port.
  input wire logic [pbpc_pkg::PBPC_ADDR_W-1:0] busAddr,
  input wire logic [pbpc_pkg::PBPC_DATA_W-1:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [pbpc_pkg::PBPC_DATA_W-1:0] busRdata,
  // Peripheral settings and pins.
  input wire pbpc_pkg::pbpc_periph_t periph,
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe_n
);
  import pbpc_pkg::*;
  logic live;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Pins are recomputed only outside both standby states.
  assign live = !swStandby && !hwStandby;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_dirRead;
    busRd && !hwStandby && busAddr == PBPC_DIR_OFFSET |=> busRdata == PBPC_DIR_READ;
  endproperty
  a_dirRead: assert property (p_dirRead) else $error("Direction read wrong.");
  property p_unmapped;
    busRd && !hwStandby && busAddr != PBPC_DIR_OFFSET && busAddr != PBPC_LATCH_OFFSET
      |=> busRdata == PBPC_UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read wrong.");
  property p_hwClear;
    hwStandby |=> pinOe_n == PBPC_OE_N_IDLE && busRdata == 8'h00;
  endproperty
  a_hwClear: assert property (p_hwClear) else $error("Standby clear wrong.");
  property p_dirPins;
    busWr && busAddr == PBPC_DIR_OFFSET && live ##1 live && !busWr
      |=> pinOe_n[4:0] == ~$past(busWdata[4:0], 2);
  endproperty
  a_dirPins: assert property (p_dirPins) else $error("Direction not on pins.");
  property p_latchPins;
    busWr && busAddr == PBPC_LATCH_OFFSET && live ##1 live && !busWr
      |=> pinOut[4:0] == $past(busWdata[4:0], 2);
  endproperty
  a_latchPins: assert property (p_latchPins) else $error("Latch not on pins.");
  property p_freeze;
    $past(swStandby) && $past(rst_n) && !$past(hwStandby) |-> $stable(pinOut) && $stable(pinOe_n);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Pins moved in standby.");
  property p_rxOwn;
    (periph.receiverEnable || periph.smartCardSelect) && live |=> pinOe_n[7];
  endproperty
  a_rxOwn: assert property (p_rxOwn) else $error("Receive pin driven.");
  property p_txDrive;
    periph.transmitterEnable && !periph.smartCardSelect && live
      |=> !pinOe_n[6] && pinOut[6] == $past(periph.serialTxData);
  endproperty
  a_txDrive: assert property (p_txDrive) else $error("Transmit pin wrong.");
  property p_scTx;
    periph.smartCardSelect && live |=> pinOe_n[6] == !$past(periph.serialTxDrive);
  endproperty
  a_scTx: assert property (p_scTx) else $error("Smart card enable wrong.");
  property p_strobe;
    periph.lowerColumnStrobeSel && live
      |=> !pinOe_n[5] && pinOut[5] == $past(periph.lowerColumnStrobe);
  endproperty
  a_strobe: assert property (p_strobe) else $error("Strobe pin wrong.");
  property p_clkIn;
    periph.clockEnableHi && !periph.lowerColumnStrobeSel && live |=> pinOe_n[5];
  endproperty
  a_clkIn: assert property (p_clkIn) else $error("Clock input driven.");
  c_scFloat: cover property (periph.smartCardSelect && !periph.serialTxDrive);
  c_swWrite: cover property (swStandby ##1 busWr);
  c_latchRd: cover property (busRd && busAddr == PBPC_LATCH_OFFSET);
endmodule : pbpc_monitor

bind pbpc_port pbpc_monitor #(.W(W)) u_mon (.clk(clk), .rst_n(rst_n), .hwStandby(hwStandby),
  .swStandby(swStandby), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
  .busRd(busRd), .busRdata(busRdata), .periph(periph), .pinOut(pinOut), .pinOe_n(pinOe_n));

// ===== sim/pbpc_board.sv
// Purpose: Board model at the port pins.
// Assumes: Undriven pins sit at a board level chosen by the bench.
// Notes: Purely combinational.
`timescale 1ns/1ps
module pbpc_board #(
  parameter int W = 8
) (
  // Port drive.
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe_n,
  // Board level and resulting pins.
  input wire logic [W-1:0] board,
  output logic [W-1:0] pinIn
);
  // A pin shows the port drive when enabled, else the board level.
  assign pinIn = (pinOe_n & board) | (~pinOe_n & pinOut);
endmodule : pbpc_board

// ===== sim/pbpc_port_bench.sv
// Purpose: Self-checking bench for the port B pin control block.
// Assumes: Board pulls undriven pins to a fixed pattern.
// Notes: Every scenario task drives and judges on its own.
`timescale 1ns/1ps
module pbpc_port_bench;
  import pbpc_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic hwStandby = 1'h0;
  logic swStandby = 1'h0;
  logic [19:0] busAddr = 20'h0_0000;
  logic [7:0] busWdata = 8'h00;
  logic busWr = 1'h0;
  logic busRd = 1'h0;
  logic [7:0] busRdata;
  pbpc_periph_t periph = '0;
  pbpc_to_periph_t toPeriph;
  logic [7:0] pinIn;
  logic [7:0] pinOut;
  logic [7:0] pinOe_n;
  logic [7:0] board = 8'h3C;
  logic [7:0] d;
  pbpc_periph_t p;
  int bad_count = 0;
  int checked = 0;

  // ==========================================================================
  // Clock, design and board
  // ==========================================================================
  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;
  pbpc_port #(.W(8)) dut (.clk(clk), .rst_n(rst_n), .hwStandby(hwStandby),
    .swStandby(swStandby), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .periph(periph), .toPeriph(toPeriph),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n));
  pbpc_board #(.W(8)) boardU (.pinOut(pinOut), .pinOe_n(pinOe_n), .board(board), .pinIn(pinIn));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wr(input logic [19:0] a, input logic [7:0] v);
    @(posedge clk);
    busWr <= 1'h1;
    busAddr <= a;
    busWdata <= v;
    @(posedge clk);
    busWr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk);
    busRd <= 1'h1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'h0;
    #1;
    cmp("busRdata", exp, busRdata);
  endtask : rd
  // Applies peripheral settings, then checks one pin as 2 when floating, else its drive.
  task automatic own(input pbpc_periph_t s, input logic [1:0] exp, input int pin);
    @(posedge clk);
    periph <= s;
    settle(2);
    cmp("pin", {6'h00, exp}, pinOe_n[pin] ? 8'h02 : {7'h00, pinOut[pin]});
  endtask : own
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    cmp("pinOe_n", 8'hFF, pinOe_n);
    rd(PBPC_DIR_OFFSET, 8'hFF);
    rd(20'h0_0000, 8'h00);
    rd(PBPC_LATCH_OFFSET, 8'h3C);
    wr(PBPC_DIR_OFFSET, 8'hF0);
    wr(PBPC_LATCH_OFFSET, 8'hA5);
    settle(6);
    cmp("pinOe_n", 8'h0F, pinOe_n);
    cmp("pinOut", 8'hA0, pinOut & 8'hF0);
    rd(PBPC_LATCH_OFFSET, 8'hAC);
    rd(PBPC_DIR_OFFSET, 8'hFF);
  endtask : t_regs
  task automatic t_pins;
    p = '0;
    p.patternEnable = 3'h7;
    p.patternOut = 3'h2;
    own(p, 2'h1, 6);
    own(p, 2'h0, 5);
    wr(PBPC_DIR_OFFSET, 8'hD0);
    settle(2);
    cmp("pinOe_n", 8'h2F, pinOe_n);
    wr(PBPC_DIR_OFFSET, 8'hFF);
    wr(PBPC_LATCH_OFFSET, 8'h00);
    p = '0;
    p.receiverEnable = 1'h1;
    own(p, 2'h2, 7);
    settle(4);
    cmp("serialRxIn", 8'h00, {7'h00, toPeriph.serialRxIn});
    p.transmitterEnable = 1'h1;
    p.serialTxData = 1'h1;
    own(p, 2'h1, 6);
    p.smartCardSelect = 1'h1;
    own(p, 2'h2, 6);
    p.serialTxDrive = 1'h1;
    own(p, 2'h1, 6);
    p.clockEnableLo = 1'h1;
    p.serialClkData = 1'h1;
    own(p, 2'h1, 5);
    p.clockEnableHi = 1'h1;
    own(p, 2'h2, 5);
    settle(4);
    cmp("serialClkIn", 8'h01, {7'h00, toPeriph.serialClkIn});
    p.lowerColumnStrobeSel = 1'h1;
    p.lowerColumnStrobe = 1'h1;
    own(p, 2'h1, 5);
    p = '0;
    p.syncSelect = 1'h1;
    p.serialClkData = 1'h1;
    own(p, 2'h1, 5);
    own('0, 2'h0, 5);
  endtask : t_pins
  task automatic t_standby;
    wr(PBPC_LATCH_OFFSET, 8'h81);
    @(posedge clk);
    swStandby <= 1'h1;
    wr(PBPC_DIR_OFFSET, 8'h00);
    wr(PBPC_LATCH_OFFSET, 8'h7E);
    settle(2);
    cmp("pinOe_n", 8'h00, pinOe_n);
    cmp("pinOut", 8'h81, pinOut);
    @(posedge clk);
    swStandby <= 1'h0;
    settle(2);
    cmp("pinOe_n", 8'hFF, pinOe_n);
    wr(PBPC_DIR_OFFSET, 8'hFF);
    rd(PBPC_LATCH_OFFSET, 8'h7E);
    @(posedge clk);
    hwStandby <= 1'h1;
    @(posedge clk);
    hwStandby <= 1'h0;
    #1;
    cmp("pinOe_n", 8'hFF, pinOe_n);
    wr(PBPC_DIR_OFFSET, 8'hFF);
    rd(PBPC_LATCH_OFFSET, 8'h00);
  endtask : t_standby

  // Main sequence: reset for two cycles, then each scenario.
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    settle(4);
    t_regs();
    t_pins();
    t_standby();
    report_and_stop();
  end
endmodule : pbpc_port_bench
